// ### hdl/cod_consts.vh
// constants for the clock output driver configuration block
// assumes byte-wide registers at their own offsets on a plain strobe port
`ifndef COD_CONSTS_VH
`define COD_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define COD_ADDR_W        16
`define COD_OFF_G0_A      16'h10d7
`define COD_OFF_G0_B      16'h10d8
`define COD_OFF_G0_C      16'h10d9
`define COD_OFF_G1_A      16'h14d7
`define COD_OFF_G1_B      16'h14d8
`define COD_OFF_MUTE      16'h10e0
`define COD_OFF_STATUS    16'h10e1

// ****************************************
// fields
// ****************************************
`define COD_BIT_SRC       0
`define COD_LVL_LO        1
`define COD_LVL_HI        2
`define COD_MODE_LO       3
`define COD_MODE_HI       4
`define COD_BIT_BYP       5
`define COD_CFG_W         6
`define COD_CFG_RST       6'h00

`define COD_LVL_7P5       2'h0
`define COD_LVL_12P5      2'h1
`define COD_LVL_15        2'h2
`define COD_MODE_DIFF     2'h0
`define COD_MODE_SE       2'h1
`define COD_MODE_DUAL     2'h2

`define COD_NPAIR         5
`define COD_NPAIR_G0      3

`endif

// ### hdl/cod_pair.v
// one output pin pair: routing, source/sink, drive level and mute retiming
// assumes divider levels arrive synchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "cod_consts.vh"
module cod_pair (
  input  wire                  core_clk_i,
  input  wire                  rst_i,
  input  wire [`COD_CFG_W-1:0] cfg_i,
  input  wire                  mute_i,
  input  wire                  pri_div_i,
  input  wire                  sec_div_i,
  output reg                   true_on_o,
  output reg                   comp_on_o,
  output reg                   source_o,
  output reg  [1:0]            level_o,
  output reg                   sec_pwr_o,
  output reg                   muted_o
);
  wire [1:0] mode = cfg_i[`COD_MODE_HI:`COD_MODE_LO];
  wire       byp  = cfg_i[`COD_BIT_BYP];
  reg        pri_d_r;
  reg        true_nxt;
  reg        comp_nxt;
  reg        muted_nxt;

  // ****************************************
  // routing
  // ****************************************
  always @* begin
    case (mode)
      `COD_MODE_DIFF: begin
        true_nxt = pri_div_i;
        comp_nxt = ~pri_div_i;
      end
      `COD_MODE_SE: begin
        true_nxt = pri_div_i;
        comp_nxt = pri_div_i;
      end
      `COD_MODE_DUAL: begin
        true_nxt = pri_div_i;
        comp_nxt = sec_div_i;
      end
      default: begin
        // undefined mode: hold both elements off
        true_nxt = 1'b0;
        comp_nxt = 1'b0;
      end
    endcase
  end

  // ****************************************
  // mute retiming
  // ****************************************
  // mute engages only on the primary falling edge unless bypassed, so a primary high phase is never cut short; a dual-mode secondary phase can be
  always @* begin
    if (!mute_i)
      muted_nxt = 1'b0;
    else if (byp || muted_o)
      muted_nxt = 1'b1;
    else
      muted_nxt = pri_d_r & ~pri_div_i;
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pri_d_r   <= 1'b0;
      true_on_o <= 1'b0;
      comp_on_o <= 1'b0;
      source_o  <= 1'b0;
      level_o   <= 2'h0;
      sec_pwr_o <= 1'b0;
      muted_o   <= 1'b0;
    end else begin
      pri_d_r   <= pri_div_i;
      muted_o   <= muted_nxt;
      true_on_o <= true_nxt & ~muted_nxt;
      comp_on_o <= comp_nxt & ~muted_nxt;
      source_o  <= cfg_i[`COD_BIT_SRC];
      level_o   <= cfg_i[`COD_LVL_HI:`COD_LVL_LO];
      sec_pwr_o <= (mode == `COD_MODE_DUAL);
    end
  end
endmodule // cod_pair
`default_nettype wire

// ### hdl/cod_top.v
// clock output driver configuration: five pair registers and five pin pairs
// assumes a single-cycle strobe register port and divider levels on core_clk_i
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cod_consts.vh"
module cod_top #(
  parameter NPAIR = `COD_NPAIR
) (
  input  wire                   core_clk_i,
  input  wire                   rst_i,
  input  wire [`COD_ADDR_W-1:0] addr_i,
  input  wire [7:0]             wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [7:0]             rdata_o,
  input  wire                   first_loop_pri_i,
  input  wire                   first_loop_sec_i,
  input  wire                   second_loop_pri_i,
  input  wire                   second_loop_sec_i,
  input  wire [NPAIR-1:0]       mute_cmd_i,
  output wire [NPAIR-1:0]       true_pin_on_o,
  output wire [NPAIR-1:0]       complement_pin_on_o,
  output wire [NPAIR-1:0]       source_current_o,
  output wire [2*NPAIR-1:0]     drive_level_o,
  output wire [NPAIR-1:0]       sec_div_pwr_o
);
  // first_loop_* are single bits shared by every first-group pair (a,b,c)
  // and second_loop_* are single bits shared by both second-group pairs (a,b)

  // ****************************************
  // pair configuration registers
  // ****************************************
  reg  [`COD_CFG_W-1:0] cfg_r [0:NPAIR-1];
  reg  [NPAIR-1:0]      sw_mute_r;
  wire [NPAIR-1:0]      muted;
  reg  [2:0]            sel;
  reg                   hit;

  // ascending offsets map to subgroups in order
  always @* begin
    hit = 1'b1;
    case (addr_i)
      `COD_OFF_G0_A: sel = 3'h0;
      `COD_OFF_G0_B: sel = 3'h1;
      `COD_OFF_G0_C: sel = 3'h2;
      `COD_OFF_G1_A: sel = 3'h3;
      `COD_OFF_G1_B: sel = 3'h4;
      default: begin
        sel = 3'h7;
        hit = 1'b0;
      end
    endcase
  end

  integer k;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (k = 0; k < NPAIR; k = k + 1)
        cfg_r[k] <= `COD_CFG_RST;
      sw_mute_r <= {NPAIR{1'b0}};
      rdata_o   <= 8'h00;
    end else begin
      if (wr_i && hit)
        cfg_r[sel] <= wdata_i[`COD_CFG_W-1:0];
      if (wr_i && addr_i == `COD_OFF_MUTE)
        sw_mute_r <= wdata_i[NPAIR-1:0];
      if (rd_i) begin
        if (hit)
          rdata_o <= {2'h0, cfg_r[sel]};
        else if (addr_i == `COD_OFF_MUTE)
          rdata_o <= {3'h0, sw_mute_r};
        else if (addr_i == `COD_OFF_STATUS)
          rdata_o <= {3'h0, muted};
        else
          rdata_o <= 8'h00; // unmapped reads as zero
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // ****************************************
  // pin pairs
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NPAIR; g = g + 1) begin : pair
      // group membership fixes the loop channel; no cross routing exists
      wire pri = (g < `COD_NPAIR_G0) ? first_loop_pri_i  : second_loop_pri_i;
      wire sec = (g < `COD_NPAIR_G0) ? first_loop_sec_i  : second_loop_sec_i;
      cod_pair u_pair (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .cfg_i      (cfg_r[g]),
        .mute_i     (mute_cmd_i[g] | sw_mute_r[g]),
        .pri_div_i  (pri),
        .sec_div_i  (sec),
        .true_on_o  (true_pin_on_o[g]),
        .comp_on_o  (complement_pin_on_o[g]),
        .source_o   (source_current_o[g]),
        .level_o    (drive_level_o[2*g+1:2*g]),
        .sec_pwr_o  (sec_div_pwr_o[g]),
        .muted_o    (muted[g])
      );
    end
  endgenerate
endmodule // cod_top
`default_nettype wire

// ### test/cod_chk.sv
// checker on cod_top ports, bound at the foot
// assumes mode 3 is never programmed
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checks
// ****************
module cod_chk #(parameter NPAIR = 5) (
  input wire logic               core_clk_i,
  input wire logic               rst_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [7:0]         rdata_o,
  input wire logic               first_loop_pri_i,
  input wire logic               second_loop_pri_i,
  input wire logic               second_loop_sec_i,
  input wire logic [NPAIR-1:0]   mute_cmd_i,
  input wire logic [NPAIR-1:0]   true_pin_on_o,
  input wire logic [NPAIR-1:0]   complement_pin_on_o,
  input wire logic [NPAIR-1:0]   source_current_o,
  input wire logic [2*NPAIR-1:0] drive_level_o,
  input wire logic [NPAIR-1:0]   sec_div_pwr_o
);
  logic [2:0]       ws_r;
  logic [NPAIR-1:0] m1_r, m2_r, q;
  // config settles within three cycles of a write
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i) {ws_r, m1_r, m2_r} <= '0;
    else {ws_r, m1_r, m2_r} <= {ws_r[1:0], wr_i, mute_cmd_i, m1_r};
  assign q = ~(mute_cmd_i | m1_r | m2_r);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_src_hold: assert property (ws_r == 0 |-> $stable(source_current_o))
    else $error("source moved");
  a_lvl_hold: assert property (ws_r == 0 |-> $stable(drive_level_o))
    else $error("level moved");
  a_pwr_hold: assert property (ws_r == 0 |-> $stable(sec_div_pwr_o))
    else $error("power moved");
  a_rst_dflt: assert property ($fell(rst_i) |-> !source_current_o && !drive_level_o && !sec_div_pwr_o)
    else $error("bad defaults");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("stray read data");
  a_g0_route: assert property (q[0] |-> true_pin_on_o[0] == $past(first_loop_pri_i))
    else $error("group 0 route");
  a_g1_route: assert property (q[3] |-> true_pin_on_o[3] == $past(second_loop_pri_i))
    else $error("group 1 route");
  property dual_ok;
    q[3] && ws_r == 0 && sec_div_pwr_o[3] |-> complement_pin_on_o[3] == $past(second_loop_sec_i);
  endproperty
  a_dual_comp: assert property (dual_ok)
    else $error("dual route");
  c_dual: cover property (sec_div_pwr_o[3]);
  c_mute: cover property (mute_cmd_i[4] ##2 !true_pin_on_o[4]);
  c_read: cover property (rd_i ##1 rdata_o != 8'h00);
endmodule // cod_chk
bind cod_top cod_chk #(.NPAIR(NPAIR)) i_chk (.*);
`default_nettype wire

// ### test/cod_rx_model.sv
// receiver side: true pin level as its load sees it
// assumes ground loads when sourcing, pull-ups when sinking
`timescale 1ns/1ps
`default_nettype none
// ****************
// receiver model
// ****************
module cod_rx_model (
  input  wire logic [4:0] true_on_i,
  input  wire logic [4:0] source_i,
  output logic      [4:0] line_o
);
  assign line_o = ~(true_on_i ^ source_i);
endmodule // cod_rx_model
`default_nettype wire

// ### test/clock_output_driver_config_tb_top.sv
// bench for cod_top with receiver model
// assumes the checker binds itself
`timescale 1ns/1ps
`default_nettype none
// ****************
// bench
// ****************
module clock_output_driver_config_tb_top;
  logic        core_clk_i, rst_i, wr_i, rd_i, rd_d, fp, fs, sp, ss;
  logic [15:0] addr_i;
  logic [7:0]  wdata_i, v, rdata_o, exp_q[$];
  logic [4:0]  mute_cmd_i, tp, cp, sc, pw, ln, es, ep;
  logic [9:0]  dl, el;
  int          fails = 0, checks_done = 0;
  logic [15:0] offs [6] = '{16'h10d7, 16'h10d8, 16'h10d9, 16'h14d7, 16'h14d8, 16'h1234};
  logic [7:0]  cfg [5] = '{8'h01, 8'h0a, 8'h15, 8'h10, 8'h24};
  cod_top i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .first_loop_pri_i(fp), .first_loop_sec_i(fs), .second_loop_pri_i(sp),
    .second_loop_sec_i(ss), .mute_cmd_i(mute_cmd_i), .true_pin_on_o(tp), .complement_pin_on_o(cp),
    .source_current_o(sc), .drive_level_o(dl), .sec_div_pwr_o(pw));
  cod_rx_model i_rx (.true_on_i(tp), .source_i(sc), .line_o(ln));
  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge core_clk_i) begin
    rd_d <= rd_i;
    if (rd_d === 1'b1) chk("rd", rdata_o, exp_q.pop_front());
  end
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (3000) @(posedge core_clk_i);
    fails++;
    end_of_test();
  end
  initial begin
    {rst_i, wr_i, rd_i, fp, fs, sp, ss} = 7'h40;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    mute_cmd_i = 5'h00;
    void'($urandom(8107));
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      bus(0, offs[k], 8'h00);
      v = 8'($urandom);
      if (v[4:3] == 2'h3) v[4] = 1'b0;
      bus(1, offs[k], v);
      bus(0, offs[k], k < 5 ? v & 8'h3f : 8'h00);
    end
    for (int k = 0; k < 5; k++) begin
      bus(1, offs[k], cfg[k]);
      es[k] = cfg[k][0];
      el[2*k+:2] = cfg[k][2:1];
      ep[k] = cfg[k][4:3] == 2'h2;
    end
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("src", sc, es);
    chk("lvl", dl, el);
    chk("pwr", pw, ep);
    repeat (40) begin
      @(posedge core_clk_i);
      {fp, fs, sp, ss} <= 4'($urandom);
      @(posedge core_clk_i);
      #1;
      chk("true", tp, {sp, sp, fp, fp, fp});
      chk("comp", cp, {!sp, ss, fs, fp, !fp});
      chk("rx", ln[0], fp);
    end
    @(posedge core_clk_i);
    {fp, sp} <= 2'h3;
    @(posedge core_clk_i);
    mute_cmd_i <= 5'h11;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("bypass", tp[4], 1'b0);
    chk("retime", tp[0], 1'b1);
    @(posedge core_clk_i);
    fp <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("muted", {tp[0], cp[0]}, 2'h0);
    // software mute only on pairs already muted, so the route checks stay valid
    bus(1, 16'h10e0, 8'h11);
    bus(0, 16'h10e0, 8'h11);
    bus(0, 16'h10e1, 8'h11);
    bus(1, 16'h10e0, 8'h00);
    @(posedge core_clk_i);
    mute_cmd_i <= 5'h00;
    repeat (4) @(posedge core_clk_i);
    #1;
    chk("unmute", {tp[4], cp[0]}, 2'h3);
    bus(1, offs[0], 8'h00);
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("sink", {sc[0], dl[1:0], ln[0]}, 4'h1);
    end_of_test();
  end
endmodule // clock_output_driver_config_tb_top
`default_nettype wire
